/* File: shared/t16pe_map.svh */
// register offsets, field positions, reset values and timing counts of the timer
`ifndef T16PE_MAP_SVH
`define T16PE_MAP_SVH
`define T16PE_DIR_OFS 16'hff23
`define T16PE_PRESC_OFS 16'hff61
`define T16PE_DIR_RST 8'hff
`define T16PE_PRESC_RST 8'h00
`define T16PE_DIR_FIXED 8'hfc
`define T16PE_PRESC_MASK 8'hf3
`define T16PE_CLK_LSB 0
`define T16PE_PRI_EDGE_LSB 4
`define T16PE_SEC_EDGE_LSB 6
`define T16PE_DIV4_LAST 8'h03
`define T16PE_DIV256_LAST 8'hff
`define T16PE_CNT_MAX 16'hffff
`endif

/* File: shared/t16pe_pkg.sv */
// types of the prescaled 16-bit timer block
package t16pe_pkg;
    typedef enum logic [1:0] {T16PE_STOP, T16PE_CLR_EDGE, T16PE_FREE, T16PE_CLR_MATCH} t16pe_mode_t;
    typedef struct packed {
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } t16pe_cpu_t;
    typedef struct packed {
        logic [2:0] sync;
        logic cand;
        logic filt;
        logic last;
    } t16pe_pin_t;
    typedef struct packed {
        logic [7:0] presc;
        logic [1:0] dir;
        logic [7:0] div;
        logic [15:0] cnt;
        logic [15:0] cap;
        t16pe_pin_t [1:0] pin;
        logic cap_due;
        logic irq0;
        logic irq1;
        logic ovf;
        logic [7:0] rdata;
    } t16pe_state_t;
endpackage

/* File: hw/t16pe_top.sv */
// prescaler, edge select, noise filter, port direction and 16-bit counter
`timescale 1ns/1ps
`include "t16pe_map.svh"
module t16pe_top (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // cpu memory port
    input wire t16pe_pkg::t16pe_cpu_t cpu_i,
    output logic [7:0] cpu_rdata_o,
    // mode control from the surrounding timer registers
    input wire t16pe_pkg::t16pe_mode_t timer_mode_control_i,
    input wire logic [15:0] compare_reg_zero_i,
    input wire logic capture_en_i,
    input wire logic overflow_clear_i,
    // pins: primary input, shared secondary input / timer output
    input wire logic primary_input_pin_i,
    output logic primary_pin_oe_o,
    input wire logic secondary_input_pin_i,
    output logic timer_output_pin_o,
    output logic timer_output_oe_o,
    // status
    output logic [15:0] main_counter_o,
    output logic [15:0] compare_reg_one_o,
    output logic overflow_flag_o,
    output logic compare_zero_irq_o,
    output logic compare_one_irq_o
);
    import t16pe_pkg::*;

    t16pe_state_t st_reg;
    t16pe_state_t st_next;
    logic running;
    logic [1:0] clk_sel;
    logic tick;
    logic pri_edge;
    logic sec_edge;
    logic samp;
    logic [1:0] pin_raw;

    // edge code 00 fall, 01 rise, 11 both; 10 is left to software to avoid
    function automatic logic edge_hit(input logic [1:0] sel, input logic now_lvl,
                                      input logic old_lvl);
        logic rise;
        logic fall;
        rise = now_lvl & ~old_lvl;
        fall = ~now_lvl & old_lvl;
        case (sel)
            2'b00: edge_hit = fall;
            2'b01: edge_hit = rise;
            2'b11: edge_hit = rise | fall;
            default: edge_hit = 1'b0;
        endcase
    endfunction

    assign running = (timer_mode_control_i != T16PE_STOP);
    assign clk_sel = st_reg.presc[`T16PE_CLK_LSB +: 2];
    assign pin_raw = {secondary_input_pin_i, primary_input_pin_i};

    // edges seen against the level held over the stopped interval
    assign pri_edge = running & edge_hit(st_reg.presc[`T16PE_PRI_EDGE_LSB +: 2],
                                         st_reg.pin[0].filt, st_reg.pin[0].last);
    assign sec_edge = running & edge_hit(st_reg.presc[`T16PE_SEC_EDGE_LSB +: 2],
                                         st_reg.pin[1].filt, st_reg.pin[1].last);

    // count clock enable: every cycle, divided, or a filtered pin edge
    always_comb begin
        case (clk_sel)
            2'b00: tick = running;
            2'b01: tick = running & (st_reg.div[1:0] == 2'(`T16PE_DIV4_LAST));
            2'b10: tick = running & (st_reg.div == `T16PE_DIV256_LAST);
            default: tick = pri_edge;
        endcase
    end

    // pin-edge clock filters at full rate, otherwise at the count clock
    assign samp = (clk_sel == 2'b11) ? 1'b1 : tick;

    always_comb begin
        st_next = st_reg;
        st_next.irq0 = 1'b0;
        st_next.irq1 = 1'b0;
        st_next.div = running ? st_reg.div + 8'h01 : 8'h00;
        // three-stage synchroniser, then a two-sample noise filter per pin
        for (int i = 0; i < 2; i++) begin
            st_next.pin[i].sync = {st_reg.pin[i].sync[1:0], pin_raw[i]};
            if (st_reg.pin[i].sync[2] == st_reg.pin[i].sync[1] && samp) begin
                st_next.pin[i].cand = st_reg.pin[i].sync[2];
                if (st_reg.pin[i].sync[2] == st_reg.pin[i].cand) begin
                    st_next.pin[i].filt = st_reg.pin[i].cand;
                end
            end
            // reference level frozen while stopped
            if (running) begin
                st_next.pin[i].last = st_reg.pin[i].filt;
            end
        end
        // counter step on each count clock
        if (!running) begin
            st_next.cnt = 16'h0000;
            st_next.cap_due = 1'b0;
        end else if (tick) begin
            st_next.cnt = st_reg.cnt + 16'h0001;
            if (st_reg.cnt == `T16PE_CNT_MAX &&
                (timer_mode_control_i != T16PE_CLR_MATCH ||
                 compare_reg_zero_i == `T16PE_CNT_MAX)) begin
                st_next.ovf = 1'b1;
            end
            if (st_reg.cnt == compare_reg_zero_i && timer_mode_control_i == T16PE_CLR_MATCH) begin
                st_next.cnt = 16'h0000;
                st_next.irq0 = 1'b1;
            end
            // irq for last capture shows one count clock later
            st_next.irq1 = st_reg.cap_due;
            st_next.cap_due = 1'b0;
        end
        // primary edge capture, restart in clear-on-edge mode
        if (running && pri_edge && clk_sel != 2'b11) begin
            if (capture_en_i) begin
                st_next.cap = st_reg.cnt;
                st_next.cap_due = 1'b1;
            end
            if (timer_mode_control_i == T16PE_CLR_EDGE) begin
                st_next.cnt = 16'h0000;
            end
        end
        // secondary edge raises compare-zero request outside clear-on-match mode
        if (sec_edge && timer_mode_control_i != T16PE_CLR_MATCH) begin
            st_next.irq0 = 1'b1;
        end
        // overflow clear loses against a new overflow in the same cycle only if the flag was clear
        if (overflow_clear_i && !(st_next.ovf && !st_reg.ovf)) begin
            st_next.ovf = 1'b0;
        end
        // register writes
        if (cpu_i.wr && cpu_i.addr == `T16PE_PRESC_OFS) begin
            st_next.presc = cpu_i.wdata & `T16PE_PRESC_MASK;
        end
        if (cpu_i.wr && cpu_i.addr == `T16PE_DIR_OFS) begin
            st_next.dir = cpu_i.wdata[1:0];
        end
        // read data, registered
        case (cpu_i.addr)
            `T16PE_PRESC_OFS: st_next.rdata = st_reg.presc;
            `T16PE_DIR_OFS: st_next.rdata = `T16PE_DIR_FIXED | {6'h00, st_reg.dir};
            default: st_next.rdata = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
            st_reg.presc <= `T16PE_PRESC_RST;
            st_reg.dir <= 2'(`T16PE_DIR_RST);
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs from flops, the enables inverted; timer output pin tied low
    assign cpu_rdata_o = st_reg.rdata;
    assign main_counter_o = st_reg.cnt;
    assign compare_reg_one_o = st_reg.cap;
    assign overflow_flag_o = st_reg.ovf;
    assign compare_zero_irq_o = st_reg.irq0;
    assign compare_one_irq_o = st_reg.irq1;
    assign primary_pin_oe_o = ~st_reg.dir[0];
    assign timer_output_oe_o = ~st_reg.dir[1];
    assign timer_output_pin_o = 1'b0;

    // assertions
    sequence wr_presc_s;
        cpu_i.wr && cpu_i.addr == `T16PE_PRESC_OFS;
    endsequence
    presc_write_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        wr_presc_s |=> st_reg.presc == ($past(cpu_i.wdata) & `T16PE_PRESC_MASK))
        else $error("prescale write not stored");
    presc_fixed_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        st_reg.presc[3:2] == 2'b00) else $error("prescale fixed bits set");
    dir_read_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        cpu_i.addr == `T16PE_DIR_OFS |=> cpu_rdata_o[7:2] == 6'h3f)
        else $error("direction fixed bits not one");
    div4_rate_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (tick && clk_sel == 2'b01 && timer_mode_control_i != T16PE_STOP
         && $stable(clk_sel)) |=> !tick [*3])
        else $error("div4 tick too close");
    match_clear_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (tick && timer_mode_control_i == T16PE_CLR_MATCH && st_reg.cnt == compare_reg_zero_i)
        |=> main_counter_o == 16'h0000 && compare_zero_irq_o)
        else $error("no clear or irq on compare match");
    // the flag is decided on the cycle before it shows, so look at that cycle's mode
    ovf_gate_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        $past(timer_mode_control_i) == T16PE_CLR_MATCH && !$past(overflow_flag_o)
        && $past(compare_reg_zero_i) != `T16PE_CNT_MAX |-> !overflow_flag_o)
        else $error("overflow with compare below max");
    ovf_roll_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (tick && st_reg.cnt == `T16PE_CNT_MAX && timer_mode_control_i == T16PE_FREE)
        |=> overflow_flag_o)
        else $error("roll without overflow");
    edge_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        !running |=> st_reg.pin[0].last == $past(st_reg.pin[0].last))
        else $error("reference level moved while stopped");
    filt_two_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        $changed(st_reg.pin[0].filt) |-> $past(samp) && $past(st_reg.pin[0].cand)
        == st_reg.pin[0].filt)
        else $error("filter moved without two samples");
    cap_irq_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        compare_one_irq_o |-> $past(tick) && $past(st_reg.cap_due))
        else $error("capture irq not on following count clock");
endmodule

/* File: verification/t16pe_pulse_src.sv */
// pulse source standing on the timer input pins
`timescale 1ns/1ps
module t16pe_pulse_src (
    // timing reference only
    input wire logic sys_clk_i,
    // pin levels
    output logic primary_o,
    output logic secondary_o
);
    // pins start low
    initial begin
        primary_o = 1'b0;
        secondary_o = 1'b0;
    end
    // move the primary pin to a level just after an edge
    task automatic set_pri(input logic v);
        @(posedge sys_clk_i);
        #1 primary_o = v;
    endtask
    // move the secondary pin to a level just after an edge
    task automatic set_sec(input logic v);
        @(posedge sys_clk_i);
        #1 secondary_o = v;
    endtask
    // n pulses, each level held width cycles; width 1 only for glitch tests
    task automatic pulses(input int n, input int width);
        repeat (n) begin
            repeat (width) @(posedge sys_clk_i);
            #1 primary_o = ~primary_o;
            repeat (width) @(posedge sys_clk_i);
            #1 primary_o = ~primary_o;
        end
    endtask
endmodule

/* File: verification/tb.sv */
// self-checking bench of the prescaled timer block
`timescale 1ns/1ps
module tb;
    import t16pe_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    t16pe_cpu_t cpu_i = '0;
    t16pe_mode_t mode = T16PE_STOP;
    logic [15:0] cmp = 16'h0001;
    logic cap_en = 1'b0;
    logic ovf_clr = 1'b0;
    logic pri, sec, pri_oe, to_pin, to_oe, ovf, irq0, irq1;
    logic [7:0] rdata;
    logic [15:0] cnt, cap;
    int failures = 0;
    int n_compared = 0;
    int n_irq0 = 0;
    int n_irq1 = 0;
    logic [15:0] cap_step = 16'h0000;
    logic [15:0] cap_last = 16'h0000;
    // clock
    always #5 sys_clk_i = ~sys_clk_i;
    t16pe_pulse_src i_src (.sys_clk_i(sys_clk_i), .primary_o(pri), .secondary_o(sec));
    t16pe_top i_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .cpu_i(cpu_i),
        .cpu_rdata_o(rdata), .timer_mode_control_i(mode), .compare_reg_zero_i(cmp),
        .capture_en_i(cap_en), .overflow_clear_i(ovf_clr), .primary_input_pin_i(pri),
        .primary_pin_oe_o(pri_oe), .secondary_input_pin_i(sec), .timer_output_pin_o(to_pin),
        .timer_output_oe_o(to_oe), .main_counter_o(cnt), .compare_reg_one_o(cap),
        .overflow_flag_o(ovf), .compare_zero_irq_o(irq0), .compare_one_irq_o(irq1));
    // irq pulses last one cycle, so count them at every edge
    always @(posedge sys_clk_i) begin
        if (irq0 === 1'b1) n_irq0++;
        // capture value already stands when its irq shows
        if (irq1 === 1'b1) begin
            n_irq1++;
            cap_step = cap - cap_last;
            cap_last = cap;
        end
    end
    task automatic check(string what, logic [15:0] exp, logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic step(int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic wr(logic [15:0] a, logic [7:0] d);
        cpu_i = '{wr: 1'b1, addr: a, wdata: d};
        step(1);
        cpu_i.wr = 1'b0;
    endtask
    // read data is registered, ready one edge after the address
    task automatic rd(logic [15:0] a, output logic [7:0] d);
        cpu_i.addr = a;
        step(1);
        d = rdata;
    endtask
    // bounded wait for the next compare irq, returns cycles waited
    task automatic wait_irq(output int n);
        n = 0;
        do begin
            step(1);
            n++;
        end while (irq0 !== 1'b1 && n < 2000);
    endtask
    function automatic int period(int sel, logic [15:0] c);
        return (c + 1) * (sel == 0 ? 1 : sel == 1 ? 4 : 256);
    endfunction
    task automatic test_done();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // watchdog sized well above the longest sequence
    initial begin
        #900_000;
        failures++;
        $display("watchdog expired");
        test_done();
    end
    // main sequence
    initial begin
        logic [7:0] d;
        logic [7:0] v;
        int n;
        void'($urandom(32'hb679a123));
        step(2);
        rst_n_i = 1'b1;
        rd(16'hff23, d);
        check("dir reset", 16'h00ff, {8'h00, d});
        rd(16'hff61, d);
        check("presc reset", 16'h0000, {8'h00, d});
        v = 8'($urandom);
        // forbidden edge code 10 turned into 11
        v = v | {1'b0, v[7], 1'b0, v[5], 4'h0};
        wr(16'hff61, v);
        rd(16'hff61, d);
        check("presc", {8'h00, v & 8'hf3}, {8'h00, d});
        wr(16'hff23, v);
        rd(16'hff23, d);
        check("dir", {8'h00, v | 8'hfc}, {8'h00, d});
        check("oe", {14'h0000, ~v[1], ~v[0]}, {14'h0000, to_oe, pri_oe});
        check("timer out", 16'h0000, {15'h0000, to_pin});
        wr(16'hff00, v);
        rd(16'hff00, d);
        check("unmapped", 16'h0000, {8'h00, d});
        wr(16'hff23, 8'hff);
        $display("test registers done");
        // every internal clock choice; prescale written only while stopped
        for (int s = 0; s < 3; s++) begin
            cmp = (s == 0) ? 16'($urandom_range(1, 40)) : 16'h0002;
            wr(16'hff61, 8'(s));
            mode = T16PE_CLR_MATCH;
            wait_irq(n);
            wait_irq(n);
            check("period", 16'(period(s, cmp)), 16'(n));
            check("cnt at match", 16'h0000, cnt);
            check("ovf", 16'h0000, {15'h0000, ovf});
            mode = T16PE_STOP;
            step(1);
        end
        $display("test interval done");
        // pin rises while stopped, so enabling sees an edge at once
        i_src.set_pri(1'b1);
        cmp = 16'h0002;
        wr(16'hff61, 8'h13);
        mode = T16PE_CLR_MATCH;
        step(12);
        check("cnt on enable", 16'h0001, cnt);
        i_src.pulses(1, 1);
        step(10);
        check("glitch ignored", 16'h0001, cnt);
        i_src.pulses(1, 8);
        step(10);
        check("event cnt", 16'h0002, cnt);
        n = n_irq0;
        i_src.pulses(1, 8);
        step(10);
        check("event clear", 16'h0000, cnt);
        check("event irq", 16'(n + 1), 16'(n_irq0));
        $display("test events done");
        // both edges capture while free running
        mode = T16PE_STOP;
        step(1);
        wr(16'hff61, 8'h30);
        cap_en = 1'b1;
        mode = T16PE_FREE;
        n = n_irq1;
        i_src.pulses(2, 8);
        step(10);
        check("capture irqs", 16'(n + 4), 16'(n_irq1));
        check("capture step", 16'h0008, cap_step);
        // secondary pin: only its falling edge is selected
        n = n_irq0;
        i_src.set_sec(1'b1);
        step(8);
        i_src.set_sec(1'b0);
        step(8);
        check("sec edge irq", 16'(n + 1), 16'(n_irq0));
        $display("test capture done");
        // full wrap from zero sets the sticky flag
        cap_en = 1'b0;
        mode = T16PE_STOP;
        step(1);
        mode = T16PE_FREE;
        step(65540);
        check("ovf set", 16'h0001, {15'h0000, ovf});
        ovf_clr = 1'b1;
        step(1);
        ovf_clr = 1'b0;
        step(1);
        check("ovf cleared", 16'h0000, {15'h0000, ovf});
        $display("test overflow done");
        test_done();
    end
endmodule
